// ==== scp_host_model.sv ====
// Host controller model: drives the serial port pins in SPI or I2C mode.
// Assumes the bench clock paces every pin change; tasks called by the bench.

`timescale 1ns/10ps

module scp_host_model (
  input wire logic clk,
  input wire logic serialDataOe,
  input wire logic serialReadbackOutput,
  output logic modeI2c,
  output logic chipSelect,
  output logic serialDataIn,
  output logic serialClock
);
  logic sdaHost;

  // ****************
  // Pin drive
  // ****************
  // Open drain with pull-up in I2C; device can only pull low
  assign serialDataIn = modeI2c ? (sdaHost & ~serialDataOe) : sdaHost;

  initial begin
    modeI2c = 1'b0;
    chipSelect = 1'b1;
    sdaHost = 1'b1;
    serialClock = 1'b0;
  end

  // One clock phase of 4 clk; data moves mid-phase, never with the clock
  task automatic step(input logic c, input logic d);
    @(posedge clk);
    serialClock <= c;
    repeat (2) @(posedge clk);
    sdaHost <= d;
    @(posedge clk);
  endtask

  // ****************
  // SPI frame
  // ****************
  // Two 8-bit words MSB first, sampled on rise
  task automatic spi_xfer(input logic [15:0] w, output logic [7:0] rd);
    int i;
    rd = 8'h00;
    @(posedge clk);
    chipSelect <= 1'b0;
    for (i = 15; i >= 0; i--) begin
      step(1'b0, w[i]);
      step(1'b1, w[i]);
      @(negedge clk);
      if (i < 8) begin
        rd[i] = serialReadbackOutput;
      end
    end
    // Idle data shows the inverse so stale bits cannot pass
    step(1'b0, ~w[0]);
    @(posedge clk);
    chipSelect <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  // ****************
  // I2C frame
  // ****************
  task automatic go_i2c();
    @(posedge clk);
    modeI2c <= 1'b1;
    serialClock <= 1'b1;
    repeat (8) @(posedge clk);
  endtask

  task automatic set_cs(input logic v);
    @(posedge clk);
    chipSelect <= v;
    repeat (8) @(posedge clk);
  endtask

  // Device SDA lags a clock fall by more than half a period, so the
  // low phase before each byte and before its ack is doubled
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    int i;
    step(1'b0, b[7]);
    for (i = 7; i >= 0; i--) begin
      step(1'b0, b[i]);
      step(1'b1, b[i]);
    end
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    @(negedge clk);
    ack = ~serialDataIn;
  endtask

  task automatic i2c_write(input logic [6:0] a, input logic [7:0] x,
    input logic [7:0] d, output logic ack);
    logic k;
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    i2c_byte({a, 1'b0}, ack);
    if (ack) begin
      i2c_byte(x, k);
      i2c_byte(d, k);
    end
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask

  // One byte from the current index, then master nack and stop
  task automatic i2c_read(input logic [6:0] a, output logic ack,
    output logic [7:0] rd);
    int i;
    rd = 8'h00;
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    i2c_byte({a, 1'b1}, ack);
    for (i = 7; i >= 0; i--) begin
      step(1'b0, 1'b1);
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      @(negedge clk);
      rd[i] = serialDataIn;
    end
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
endmodule

// ==== scp_serial_port.sv ====
// Serial control port (SPI or I2C) with its status and control pins.
// Assumes a host drives the serial clock; pins are async to clk.

`timescale 1ns/10ps

module scp_serial_port
  import scp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic modeI2c,
  input wire logic chipSelect,
  input wire logic serialDataIn,
  input wire logic serialClock,
  input wire logic rfOutputDisable,
  input wire logic pllLocked,
  output logic serialDataOut,
  output logic serialDataOe,
  output logic serialReadbackOutput,
  output logic rfOutputEnable,
  output logic lockIndicator,
  output logic loMonitorEnable,
  output logic externalLoSelect,
  output logic muxOut
);
  // ********************************************
  // State
  // ********************************************
  typedef struct packed {
    logic sclPrev;
    logic sdaPrev;
    logic csPrev;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic byteCnt;
    logic dataReady;
    logic [4:0] index;
    logic readMode;
    logic [7:0] txByte;
    scp_i2c_state_t i2cState;
    logic ackDriving;
    logic sdaOut;
    logic sdaOe;
    logic rdOut;
    logic [LATCH_COUNT-1:0][WORD_BITS-1:0] latches;
    logic rfEn;
    logic lock;
    logic loMonEn;
    logic extLo;
    logic mux;
  } scp_state_t;

  localparam scp_state_t RESET_STATE = '{
    i2cState: SCP_IDLE, loMonEn: 1'b1, default: '0};
  scp_state_t s_q, s_d;
  logic [5:0] syncOut;
  logic modeS, csS, sdaS, sclS, disS, lockS;
  logic sclRise, sclFall, csRise, i2cStart, i2cStop;
  logic [7:0] byteIn;
  // Unmapped index reads zero so a bad pointer never aliases a latch
  function automatic logic [7:0] latchRead(
    input logic [LATCH_COUNT-1:0][WORD_BITS-1:0] l,
    input logic [4:0] idx);
    latchRead = (idx < IDX_LIMIT) ? l[idx] : 8'h00;
  endfunction
  function automatic logic [6:0] slaveAddr(input logic cs);
    slaveAddr = cs ? I2C_ADDR_CS_HIGH : I2C_ADDR_CS_LOW;
  endfunction
  scp_sync #(.W(6)) u_sync (
    .clk(clk),
    .rst(rst),
    .pinIn({modeI2c, chipSelect, serialDataIn, serialClock,
            rfOutputDisable, pllLocked}),
    .pinOut(syncOut)
  );
  assign {modeS, csS, sdaS, sclS, disS, lockS} = syncOut;
  assign sclRise = sclS & ~s_q.sclPrev;
  assign sclFall = ~sclS & s_q.sclPrev;
  assign csRise = csS & ~s_q.csPrev;
  assign i2cStart = modeS & sclS & s_q.sclPrev & ~sdaS & s_q.sdaPrev;
  assign i2cStop = modeS & sclS & s_q.sclPrev & sdaS & ~s_q.sdaPrev;
  assign byteIn = {s_q.shift[6:0], sdaS};

  // ********************************************
  // Next state
  // ********************************************
  always_comb begin
    s_d = s_q;
    s_d.sclPrev = sclS;
    s_d.sdaPrev = sdaS;
    s_d.csPrev = csS;
    s_d.sdaOut = 1'b0;
    s_d.rfEn = ~disS;
    s_d.lock = lockS;
    s_d.mux = csS; // Diagnostic mirror only
    s_d.loMonEn = ~s_q.latches[CTRL_LATCH][LOMON_OFF_BIT];
    s_d.extLo = s_q.latches[CTRL_LATCH][EXT_LO_BIT];
    if (!modeS) begin
      // SPI: data pin never driven
      s_d.sdaOe = 1'b0;
      s_d.ackDriving = 1'b0;
      s_d.i2cState = SCP_IDLE;
      if (csRise) begin
        if (s_q.dataReady && !s_q.readMode && s_q.index < IDX_LIMIT) begin
          s_d.latches[s_q.index] = s_q.shift;
        end
        s_d.bitCnt = BIT_ZERO;
        s_d.byteCnt = 1'b0;
        s_d.dataReady = 1'b0;
        s_d.readMode = 1'b0;
        s_d.rdOut = 1'b0;
      end else if (!csS && sclRise) begin
        s_d.shift = byteIn; // MSB first on rise
        s_d.bitCnt = s_q.bitCnt + BIT_ONE;
        if (s_q.bitCnt == LAST_BIT) begin
          s_d.bitCnt = BIT_ZERO; // 8-bit words
          if (!s_q.byteCnt) begin
            s_d.index = byteIn[4:0];
            s_d.readMode = byteIn[READ_FLAG_BIT];
            s_d.txByte = latchRead(s_q.latches, byteIn[4:0]);
            s_d.byteCnt = 1'b1;
          end else begin
            s_d.dataReady = 1'b1;
          end
        end
      end else if (!csS && sclFall && s_q.byteCnt && s_q.readMode) begin
        s_d.rdOut = s_q.txByte[7];
        s_d.txByte = {s_q.txByte[6:0], 1'b0};
      end
    end else if (i2cStart) begin
      // Repeated start accepted anywhere; the address byte is matched again
      s_d.i2cState = SCP_ADDR;
      s_d.bitCnt = BIT_ZERO;
      s_d.sdaOe = 1'b0;
      s_d.ackDriving = 1'b0;
    end else if (i2cStop) begin
      s_d.i2cState = SCP_IDLE;
      s_d.sdaOe = 1'b0;
      s_d.ackDriving = 1'b0;
    end else begin
      case (s_q.i2cState)
        SCP_ADDR, SCP_WRITE: begin
          if (sclRise) begin
            s_d.shift = byteIn;
            s_d.bitCnt = s_q.bitCnt + BIT_ONE;
            if (s_q.bitCnt == LAST_BIT) begin
              s_d.bitCnt = BIT_ZERO;
              s_d.i2cState = SCP_ACK;
              if (s_q.i2cState == SCP_ADDR) begin
                if (byteIn[7:1] == slaveAddr(csS)) begin
                  s_d.readMode = byteIn[0];
                  s_d.byteCnt = 1'b0;
                  s_d.txByte = latchRead(s_q.latches, s_q.index);
                end else begin
                  s_d.i2cState = SCP_IDLE;
                end
              end else if (!s_q.byteCnt) begin
                s_d.index = byteIn[4:0];
                s_d.byteCnt = 1'b1;
              end else begin
                if (s_q.index < IDX_LIMIT) begin
                  s_d.latches[s_q.index] = byteIn;
                end
                s_d.index = s_q.index + IDX_ONE;
              end
            end
          end
        end
        SCP_ACK: begin
          if (sclFall) begin
            if (!s_q.ackDriving) begin
              s_d.sdaOe = 1'b1; // Pull low to acknowledge
              s_d.ackDriving = 1'b1;
            end else begin
              s_d.ackDriving = 1'b0;
              if (s_q.readMode) begin
                s_d.sdaOe = ~s_q.txByte[7];
                s_d.txByte = {s_q.txByte[6:0], 1'b0};
                s_d.bitCnt = BIT_ONE;
                s_d.i2cState = SCP_READ;
              end else begin
                s_d.sdaOe = 1'b0;
                s_d.i2cState = SCP_WRITE;
              end
            end
          end
        end
        SCP_READ: begin
          if (sclFall) begin
            if (s_q.bitCnt == BYTE_DONE) begin
              s_d.sdaOe = 1'b0;
              s_d.i2cState = SCP_RACK;
            end else begin
              s_d.sdaOe = ~s_q.txByte[7];
              s_d.txByte = {s_q.txByte[6:0], 1'b0};
              s_d.bitCnt = s_q.bitCnt + BIT_ONE;
            end
          end
        end
        SCP_RACK: begin
          if (sclRise) begin
            if (sdaS) begin
              s_d.i2cState = SCP_IDLE;
            end else begin
              s_d.index = s_q.index + IDX_ONE;
              s_d.txByte = latchRead(s_q.latches, s_q.index + IDX_ONE);
              s_d.bitCnt = BIT_ZERO;
              s_d.ackDriving = 1'b1;
              s_d.readMode = 1'b1;
              s_d.i2cState = SCP_ACK;
            end
          end
        end
        SCP_IDLE: begin
          s_d.sdaOe = 1'b0;
        end
        default: begin
          s_d.i2cState = SCP_IDLE;
          s_d.sdaOe = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end
  assign serialDataOut = s_q.sdaOut;
  assign serialDataOe = s_q.sdaOe;
  assign serialReadbackOutput = s_q.rdOut;
  assign rfOutputEnable = s_q.rfEn;
  assign lockIndicator = s_q.lock;
  assign loMonitorEnable = s_q.loMonEn;
  assign externalLoSelect = s_q.extLo;
  assign muxOut = s_q.mux;
  // ********************************************
  // Checks
  // ********************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_spi_load: assert property (
    !modeS && csRise && s_q.dataReady && !s_q.readMode
    && s_q.index < IDX_LIMIT
    |=> s_q.latches[$past(s_q.index)] == $past(s_q.shift))
    else $error("SPI word not loaded on chip select rise");
  chk_i2c_addr: assert property (
    modeS && !i2cStart && !i2cStop && s_q.i2cState == SCP_ADDR
    && sclRise && s_q.bitCnt == LAST_BIT
    |=> (s_q.i2cState == SCP_ACK) == ($past(byteIn[7:1])
    == ($past(csS) ? I2C_ADDR_CS_HIGH : I2C_ADDR_CS_LOW)))
    else $error("I2C address match wrong");
  chk_spi_nodrive: assert property (
    !modeS ##1 !modeS |-> !serialDataOe)
    else $error("Data pin driven in SPI mode");
  chk_ack_drive: assert property (
    s_q.i2cState == SCP_ACK && s_q.ackDriving && !s_q.readMode
    |-> serialDataOe && !serialDataOut)
    else $error("Acknowledge not driven low");
  chk_spi_shift: assert property (
    !modeS && !csS && !csRise && sclRise |=> s_q.shift[0] == $past(sdaS)
    && s_q.shift[7:1] == $past(s_q.shift[6:0]))
    else $error("SPI shift not MSB first on rise");
  chk_spi_rdback: assert property (
    !modeS && !csS && !csRise && sclFall && s_q.byteCnt && s_q.readMode
    |=> serialReadbackOutput == $past(s_q.txByte[7]))
    else $error("Readback bit wrong");
  chk_rf_disable: assert property (
    disS |=> !rfOutputEnable)
    else $error("RF output not disabled");
  chk_lock_follow: assert property (
    $changed(lockS) |=> lockIndicator == $past(lockS))
    else $error("Lock indicator does not follow loop");
  chk_lomon_off: assert property (
    s_q.latches[CTRL_LATCH][LOMON_OFF_BIT] |=> !loMonitorEnable)
    else $error("LO monitor not turned off");
  chk_ext_lo: assert property (
    s_q.latches[CTRL_LATCH][EXT_LO_BIT] |=> externalLoSelect)
    else $error("External LO not selected");
  cov_spi_write: cover property (!modeS && csRise && s_q.dataReady);
  cov_i2c_ack: cover property (s_q.i2cState == SCP_ACK && s_q.ackDriving);
  cov_i2c_read: cover property (s_q.i2cState == SCP_RACK);
endmodule

// ==== scp_serial_port_tb.sv ====
// Self-checking bench for the serial control port and status pins.
// Assumes the host model drives all serial pins of the port.

`timescale 1ns/10ps

module scp_serial_port_tb;
  logic clk, rst, rfOutputDisable, pllLocked;
  logic modeI2c, chipSelect, serialDataIn, serialClock;
  logic serialDataOut, serialDataOe, serialReadbackOutput, rfOutputEnable;
  logic lockIndicator, loMonitorEnable, externalLoSelect, muxOut;
  int numErrors, nChecks;

  scp_serial_port u_dut (.clk(clk), .rst(rst), .modeI2c(modeI2c),
    .chipSelect(chipSelect), .serialDataIn(serialDataIn),
    .serialClock(serialClock), .rfOutputDisable(rfOutputDisable),
    .pllLocked(pllLocked), .serialDataOut(serialDataOut),
    .serialDataOe(serialDataOe),
    .serialReadbackOutput(serialReadbackOutput),
    .rfOutputEnable(rfOutputEnable), .lockIndicator(lockIndicator),
    .loMonitorEnable(loMonitorEnable),
    .externalLoSelect(externalLoSelect), .muxOut(muxOut));

  scp_host_model u_host (.clk(clk), .serialDataOe(serialDataOe),
    .serialReadbackOutput(serialReadbackOutput), .modeI2c(modeI2c),
    .chipSelect(chipSelect), .serialDataIn(serialDataIn),
    .serialClock(serialClock));

  // ****************
  // Helpers
  // ****************
  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    nChecks++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", nChecks, numErrors);
    if (numErrors == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic test_pins();
    @(posedge clk);
    rfOutputDisable <= 1'b1;
    pllLocked <= 1'b1;
    repeat (7) @(negedge clk);
    check("rf enable", rfOutputEnable, 1'b0);
    check("lock", lockIndicator, 1'b1);
    check("mux", muxOut, 1'b1);
    @(posedge clk);
    rfOutputDisable <= 1'b0;
    pllLocked <= 1'b0;
    repeat (7) @(negedge clk);
    check("rf enable", rfOutputEnable, 1'b1);
    check("lock", lockIndicator, 1'b0);
    $display("test_pins done");
  endtask

  // Latch 30 is the top index; 31 must be dropped
  task automatic test_spi();
    logic [7:0] rd;
    u_host.spi_xfer({8'h00, 8'h03}, rd);
    @(negedge clk);
    check("lo monitor", loMonitorEnable, 1'b0);
    check("ext lo", externalLoSelect, 1'b1);
    u_host.spi_xfer({8'h02, 8'h5a}, rd);
    u_host.spi_xfer({8'h1e, 8'ha5}, rd);
    u_host.spi_xfer({8'h1f, 8'h77}, rd);
    u_host.spi_xfer({8'h82, 8'h00}, rd);
    check("read 2", rd, 8'h5a);
    u_host.spi_xfer({8'h9e, 8'h00}, rd);
    check("read 30", rd, 8'ha5);
    u_host.spi_xfer({8'h9f, 8'h00}, rd);
    check("read 31", rd, 8'h00);
    $display("test_spi done");
  endtask

  task automatic test_i2c();
    logic ack;
    logic [7:0] rd;
    u_host.go_i2c();
    u_host.i2c_write(7'h60, 8'h00, 8'h00, ack);
    check("ack 60 cs high", ack, 1'b1);
    check("sda out", serialDataOut, 1'b0);
    check("lo monitor", loMonitorEnable, 1'b1);
    check("ext lo", externalLoSelect, 1'b0);
    u_host.i2c_write(7'h40, 8'h00, 8'h03, ack);
    check("ack 40 cs high", ack, 1'b0);
    check("lo monitor", loMonitorEnable, 1'b1);
    u_host.set_cs(1'b0);
    @(negedge clk);
    check("mux low", muxOut, 1'b0);
    u_host.i2c_write(7'h40, 8'h00, 8'h03, ack);
    check("ack 40 cs low", ack, 1'b1);
    check("ext lo", externalLoSelect, 1'b1);
    u_host.i2c_write(7'h60, 8'h00, 8'h00, ack);
    check("ack 60 cs low", ack, 1'b0);
    // Data 0x96 has its MSB set: ack release must not look like a stop
    u_host.i2c_write(7'h40, 8'h1d, 8'h96, ack);
    check("ack write 29", ack, 1'b1);
    // Index now 30, which SPI loaded with 0xa5
    u_host.i2c_read(7'h40, ack, rd);
    check("ack read", ack, 1'b1);
    check("i2c read 30", rd, 8'ha5);
    @(negedge clk);
    check("sda released", serialDataOe, 1'b0);
    $display("test_i2c done");
  endtask

  // ****************
  // Run control
  // ****************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run is near 2200 clk; a hang is cut off well after that
  initial begin
    #200000;
    numErrors++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    rfOutputDisable = 1'b0;
    pllLocked = 1'b0;
    numErrors = 0;
    nChecks = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(negedge clk);
    check("lo monitor reset", loMonitorEnable, 1'b1);
    check("ext lo reset", externalLoSelect, 1'b0);
    test_pins();
    test_spi();
    test_i2c();
    report_and_stop();
  end
endmodule

// ==== scp_sync.sv ====
// Constants package for the serial control port, and the pin synchroniser.
// Assumes every pin input is asynchronous to clk.

`timescale 1ns/10ps

package scp_pkg;
  localparam int WORD_BITS = 8;
  localparam int LATCH_COUNT = 31;
  localparam int IDX_BITS = 5;
  localparam logic [6:0] I2C_ADDR_CS_HIGH = 7'h60;
  localparam logic [6:0] I2C_ADDR_CS_LOW = 7'h40;
  localparam logic [4:0] CTRL_LATCH = 5'h00;
  localparam int LOMON_OFF_BIT = 0;
  localparam int EXT_LO_BIT = 1;
  localparam int READ_FLAG_BIT = 7;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_DONE = 4'h8;
  localparam logic [3:0] BIT_ONE = 4'h1;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [4:0] IDX_ONE = 5'h01;
  localparam logic [4:0] IDX_LIMIT = 5'h1f;

  typedef enum logic [5:0] {
    SCP_IDLE = 6'b000001,
    SCP_ADDR = 6'b000010,
    SCP_ACK = 6'b000100,
    SCP_WRITE = 6'b001000,
    SCP_READ = 6'b010000,
    SCP_RACK = 6'b100000
  } scp_i2c_state_t;
endpackage

// ********************************************
// Three-stage synchroniser with agree filter
// ********************************************
module scp_sync
  import scp_pkg::*;
#(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } scp_sync_st_t;

  scp_sync_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pinIn;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Per bit: a change counts only once stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (st_q.s2[i] == st_q.s3[i]) begin
        st_d.level[i] = st_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pinOut = st_q.level;
endmodule
